// file: inc/icon_defines.vh
// Constants for the input conditioning object block
`ifndef ICON_DEFINES_VH
`define ICON_DEFINES_VH

// Object indices
`define ICON_IDX_ANALOG      16'h3220
`define ICON_IDX_ANA_MODE    16'h3221
`define ICON_IDX_SWITCHES    16'h3225
`define ICON_IDX_DIN_CTRL    16'h3240
`define ICON_IDX_ROUTING     16'h3242

// Subindices
`define ICON_SUB_COUNT       8'h00
`define ICON_SUB_ANA_ONE     8'h01
`define ICON_SUB_ANA_TWO     8'h02
`define ICON_SUB_SWITCH      8'h01
`define ICON_SUB_SF_ON       8'h01
`define ICON_SUB_INVERT      8'h02
`define ICON_SUB_OVR_SEL     8'h03
`define ICON_SUB_OVR_LVL     8'h04
`define ICON_SUB_RAW         8'h05
`define ICON_SUB_THRESH      8'h06
`define ICON_SUB_DIFF        8'h07
`define ICON_SUB_ROUTE_ON    8'h08
`define ICON_SUB_ROUTE_LAST  8'h24

// Highest subindex values
`define ICON_ANALOG_COUNT    32'h00000002
`define ICON_SWITCH_COUNT    32'h00000001
`define ICON_DIN_CTRL_COUNT  32'h00000008
`define ICON_ROUTING_COUNT   32'h00000024

// Reset values
`define ICON_RST_WORD        32'h00000000
`define ICON_RST_ANALOG      16'h0000
`define ICON_RST_ROUTE       8'h00

// Analog mode bit positions
`define ICON_AC_ONE_BIT      0
`define ICON_AC_TWO_BIT      1

// Special function bit positions
`define ICON_SF_NEG_LIMIT    0
`define ICON_SF_POS_LIMIT    1
`define ICON_SF_HOME         2

// Scaling: 20 V or 20 mA over 1024 digits = 625/32 mV or uA per digit
`define ICON_MID_SCALE       32'sh00000200
`define ICON_SCALE_MUL       32'sh00000271
`define ICON_SCALE_SHIFT     5

// Routing source codes
`define ICON_SRC_ZERO        8'h00
`define ICON_SRC_PHYS_FIRST  8'h01
`define ICON_SRC_PHYS_LAST   8'h10
`define ICON_SRC_DIP_FIRST   8'h49
`define ICON_SRC_DIP_LAST    8'h50
`define ICON_SRC_ONE         8'h80
`define ICON_SRC_INV_FIRST   8'h81
`define ICON_SRC_INV_LAST    8'h90

`endif

// file: hw/icon_route_mem.v
// Routing source table with registered read
`timescale 1ns/1ps
module icon_route_mem #(
    parameter DW    = 8,
    parameter DEPTH = 36,
    parameter AW    = 6
) (
    input  wire          clk,   // system clock
    input  wire          srst,  // synchronous reset, clears table
    input  wire          we,    // write strobe
    input  wire [AW-1:0] waddr, // write entry
    input  wire [DW-1:0] wdata, // write data
    input  wire [AW-1:0] raddr, // read entry
    output reg  [DW-1:0] rdata  // read data, one cycle later
);
    reg [DW-1:0] mem_r [0:DEPTH-1];
    integer i;

    always @(posedge clk) begin
        if (srst) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_r[i] <= {DW{1'b0}};
            end
            rdata <= {DW{1'b0}};
        end else begin
            if (we && (waddr < DEPTH)) begin
                mem_r[waddr] <= wdata;
            end
            rdata <= (raddr < DEPTH) ? mem_r[raddr] : {DW{1'b0}};
        end
    end
endmodule // icon_route_mem

// file: hw/icon_top.v
// Input conditioning objects: analog readout, switches, digital chain
//
// Contract
// RL1: Two analog inputs read as signed 16-bit, reset zero
// RL2: Voltage mode: (x-512)*20V/1024
// RL3: Current mode: x*20mA/1024, no offset
// RL4: Mode bit0 input one, bit1 input two
// RL5: Switch readout holds rotary node identifier; code shows DIP_SW instead while DIP_FITTED is set
// RL6: DIP fitted: bit0 switch one, on reads one
// RL7: Control bits 0-15 inputs, 16-31 outputs
// RL8: Enable bit gates special function; ignores 16-31
// RL9: Enable bits: negative limit, positive limit, home
// RL10: Software clears enables of unwired special inputs
// RL11: Inversion clear passes high as one
// RL12: Inversion skips clock and direction inputs
// RL13: Force enable replaces physical level
// RL14: Force value bit supplies forced level
// RL15: Raw word shows levels before forcing, inversion
// RL16: Threshold bit: clear 5V, set 24V
// RL17: Summary word combines inputs and special functions
// RL18: Summary bit n sourced by routing entry n+1
// RL19: Order: force, then invert, then summary
`timescale 1ns/1ps
`include "icon_defines.vh"
module icon_top #(
    parameter NIN    = 16,
    parameter NROUTE = 36,
    parameter [15:0] STEP_MASK = 16'h0003
) (
    input  wire        CLOCK,           // 20 MHz system clock
    input  wire        SRST,            // synchronous reset, high
    input  wire [15:0] OD_INDEX,        // object index
    input  wire [7:0]  OD_SUB,          // object subindex
    input  wire        OD_WR,           // write request pulse
    input  wire        OD_RD,           // read request pulse
    input  wire [31:0] OD_WDATA,        // write data
    output reg  [31:0] OD_RDATA,        // read data
    output reg         OD_ACK,          // answer pulse
    output reg         OD_ERR,          // abort flag with answer
    input  wire [15:0] ANA_SAMPLE_ONE,  // converter count, input one
    input  wire [15:0] ANA_SAMPLE_TWO,  // converter count, input two
    input  wire        ANA_VALID,       // new converter samples
    output reg  [31:0] ANA_PHYS_ONE,    // input one in mV or uA
    output reg  [31:0] ANA_PHYS_TWO,    // input two in mV or uA
    output reg         first_analog_current_sel,  // input one current
    output reg         second_analog_current_sel, // input two current
    input  wire [7:0]  NODE_ID_SW,      // rotary switch value
    input  wire [7:0]  DIP_SW,          // DIP switch positions
    input  wire        DIP_FITTED,      // DIP switches fitted
    input  wire [15:0] DIN,             // physical digital inputs
    input  wire        STEP_MODE,       // clock-direction mode active
    input  wire [15:0] OUT_REQ,         // requested output levels
    output reg  [15:0] DOUT,            // conditioned output levels
    output reg  [31:0] RANGE_24V,       // threshold select per input
    output reg  [31:0] DIFF_SEL,        // differential select
    output reg         NEG_LIMIT,       // negative limit active
    output reg         POS_LIMIT,       // positive limit active
    output reg         HOME_SW,         // home switch active
    output reg  [31:0] DIGITAL_INPUTS   // summary word
);
    reg  [15:0] ana_one_r;
    reg  [15:0] ana_two_r;
    reg  [1:0]  ana_mode_r;
    reg  [15:0] switch_r;
    reg  [31:0] sf_on_r;
    reg  [31:0] invert_r;
    reg  [31:0] ovr_sel_r;
    reg  [31:0] ovr_lvl_r;
    reg  [15:0] raw_r;
    reg  [31:0] route_on_r;
    reg  [31:0] route_bits_r;
    reg  [4:0]  scan_idx_r;
    reg  [4:0]  scan_pidx_r;
    reg         scan_pend_r;
    reg         p_rd_r;
    reg         p_route_r;
    reg         p_err_r;
    reg  [31:0] p_data_r;

    wire        req      = OD_RD | OD_WR;
    wire        od_route = (OD_INDEX == `ICON_IDX_ROUTING) &&
                           (OD_SUB != `ICON_SUB_COUNT) &&
                           (OD_SUB <= `ICON_SUB_ROUTE_LAST);
    wire [5:0]  od_entry = OD_SUB[5:0] - 6'h01;
    wire        mem_od   = req && od_route;
    wire [5:0]  mem_raddr = mem_od ? od_entry : {1'b0, scan_idx_r};
    wire [7:0]  mem_rdata;

    // Conditioning chain per input: force first, then invert
    wire [15:0] forced   = (ovr_sel_r[15:0] & ovr_lvl_r[15:0]) |
                           (~ovr_sel_r[15:0] & DIN);  // RL13 RL14 RL19
    wire [15:0] inv_eff  = invert_r[15:0] &
                           ~(STEP_MODE ? STEP_MASK : 16'h0000);  // RL12
    wire [15:0] cond     = forced ^ inv_eff;  // RL11 RL19
    wire [15:0] out_lvl  = ((ovr_sel_r[31:16] & ovr_lvl_r[31:16]) |
                            (~ovr_sel_r[31:16] & OUT_REQ)) ^
                           invert_r[31:16];  // RL7
    // Upper enable bits are stored but never reach the logic
    wire [2:0]  sf_act   = cond[2:0] & sf_on_r[2:0];  // RL8 RL9

    // Analog scaling: midscale offset only in voltage mode
    wire signed [31:0] ana_s1 = {{16{ana_one_r[15]}}, ana_one_r};
    wire signed [31:0] ana_s2 = {{16{ana_two_r[15]}}, ana_two_r};
    wire signed [31:0] off1 = ana_mode_r[`ICON_AC_ONE_BIT] ?
                              ana_s1 : ana_s1 - `ICON_MID_SCALE; // RL2 RL3 RL4
    wire signed [31:0] off2 = ana_mode_r[`ICON_AC_TWO_BIT] ?
                              ana_s2 : ana_s2 - `ICON_MID_SCALE; // RL2 RL3 RL4
    wire signed [31:0] prod1 = off1 * `ICON_SCALE_MUL;
    wire signed [31:0] prod2 = off2 * `ICON_SCALE_MUL;

    // Source code to level; codes without a source here read zero
    function src_level;
        input [7:0]  code;
        input [15:0] lvl;
        input [7:0]  dip;
        reg   [7:0]  k;
        begin
            src_level = 1'b0;
            k = 8'h00;
            if (code == `ICON_SRC_ONE) begin
                src_level = 1'b1;
            end else if (code >= `ICON_SRC_PHYS_FIRST &&
                         code <= `ICON_SRC_PHYS_LAST) begin
                k = code - `ICON_SRC_PHYS_FIRST;
                src_level = lvl[k[3:0]];
            end else if (code >= `ICON_SRC_INV_FIRST &&
                         code <= `ICON_SRC_INV_LAST) begin
                k = code - `ICON_SRC_INV_FIRST;
                src_level = ~lvl[k[3:0]];
            end else if (code >= `ICON_SRC_DIP_FIRST &&
                         code <= `ICON_SRC_DIP_LAST) begin
                k = code - `ICON_SRC_DIP_FIRST;
                src_level = dip[k[2:0]];
            end
        end
    endfunction

    icon_route_mem #(
        .DW    (8),
        .DEPTH (NROUTE),
        .AW    (6)
    ) u_route (
        .clk   (CLOCK),
        .srst  (SRST),
        .we    (OD_WR && od_route),
        .waddr (od_entry),
        .wdata (OD_WDATA[7:0]),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // Read mux and access check for the first answer stage
    reg [31:0] rd_mux;
    reg        hit;
    reg        ro;
    always @* begin
        rd_mux = `ICON_RST_WORD;
        hit = 1'b1;
        ro = 1'b0;
        case (OD_INDEX)
            `ICON_IDX_ANALOG: begin
                ro = 1'b1;
                case (OD_SUB)
                    `ICON_SUB_COUNT:   rd_mux = `ICON_ANALOG_COUNT;
                    `ICON_SUB_ANA_ONE: rd_mux = {{16{ana_one_r[15]}},
                                                 ana_one_r};  // RL1
                    `ICON_SUB_ANA_TWO: rd_mux = {{16{ana_two_r[15]}},
                                                 ana_two_r};  // RL1
                    default:           hit = 1'b0;
                endcase
            end
            `ICON_IDX_ANA_MODE: begin
                if (OD_SUB == `ICON_SUB_COUNT) begin
                    rd_mux = {30'h00000000, ana_mode_r};
                end else begin
                    hit = 1'b0;
                end
            end
            `ICON_IDX_SWITCHES: begin
                ro = 1'b1;
                case (OD_SUB)
                    `ICON_SUB_COUNT:  rd_mux = `ICON_SWITCH_COUNT;
                    `ICON_SUB_SWITCH: rd_mux = {16'h0000, switch_r};
                    default:          hit = 1'b0;
                endcase
            end
            `ICON_IDX_DIN_CTRL: begin
                case (OD_SUB)
                    `ICON_SUB_COUNT: begin
                        rd_mux = `ICON_DIN_CTRL_COUNT;
                        ro = 1'b1;
                    end
                    `ICON_SUB_SF_ON:    rd_mux = sf_on_r;
                    `ICON_SUB_INVERT:   rd_mux = invert_r;
                    `ICON_SUB_OVR_SEL:  rd_mux = ovr_sel_r;
                    `ICON_SUB_OVR_LVL:  rd_mux = ovr_lvl_r;
                    `ICON_SUB_RAW:      rd_mux = {16'h0000, raw_r};   // RL15
                    `ICON_SUB_THRESH:   rd_mux = RANGE_24V;
                    `ICON_SUB_DIFF:     rd_mux = DIFF_SEL;
                    `ICON_SUB_ROUTE_ON: rd_mux = route_on_r;
                    default:            hit = 1'b0;
                endcase
            end
            `ICON_IDX_ROUTING: begin
                if (OD_SUB == `ICON_SUB_COUNT) begin
                    rd_mux = `ICON_ROUTING_COUNT;
                    ro = 1'b1;
                end else if (!od_route) begin
                    hit = 1'b0;
                end
            end
            default: hit = 1'b0;
        endcase
    end

    wire wr_ok = OD_WR && hit && !ro;
    wire din_wr = wr_ok && (OD_INDEX == `ICON_IDX_DIN_CTRL);

    // Register file and two-stage answer pipeline
    always @(posedge CLOCK) begin
        if (SRST) begin
            ana_one_r      <= `ICON_RST_ANALOG;
            ana_two_r      <= `ICON_RST_ANALOG;
            ana_mode_r     <= 2'b00;
            switch_r       <= 16'h0000;
            sf_on_r        <= `ICON_RST_WORD;
            invert_r       <= `ICON_RST_WORD;
            ovr_sel_r      <= `ICON_RST_WORD;
            ovr_lvl_r      <= `ICON_RST_WORD;
            raw_r          <= 16'h0000;
            RANGE_24V      <= `ICON_RST_WORD;
            DIFF_SEL       <= `ICON_RST_WORD;
            route_on_r     <= `ICON_RST_WORD;
            p_rd_r         <= 1'b0;
            p_route_r      <= 1'b0;
            p_err_r        <= 1'b0;
            p_data_r       <= `ICON_RST_WORD;
            OD_RDATA       <= `ICON_RST_WORD;
            OD_ACK         <= 1'b0;
            OD_ERR         <= 1'b0;
            first_analog_current_sel  <= 1'b0;
            second_analog_current_sel <= 1'b0;
        end else begin
            if (ANA_VALID) begin
                ana_one_r <= ANA_SAMPLE_ONE;  // RL1
                ana_two_r <= ANA_SAMPLE_TWO;  // RL1
            end
            switch_r <= DIP_FITTED ? {8'h00, DIP_SW} :
                                     {8'h00, NODE_ID_SW};  // RL5 RL6
            raw_r <= DIN;  // RL15
            first_analog_current_sel  <= ana_mode_r[`ICON_AC_ONE_BIT];
            second_analog_current_sel <= ana_mode_r[`ICON_AC_TWO_BIT];
            if (wr_ok && OD_INDEX == `ICON_IDX_ANA_MODE) begin
                ana_mode_r <= OD_WDATA[1:0];  // RL4
            end
            // Raw word is writable but always shows the pins
            if (din_wr) begin
                case (OD_SUB)
                    `ICON_SUB_SF_ON:    sf_on_r    <= OD_WDATA;
                    `ICON_SUB_INVERT:   invert_r   <= OD_WDATA;
                    `ICON_SUB_OVR_SEL:  ovr_sel_r  <= OD_WDATA;
                    `ICON_SUB_OVR_LVL:  ovr_lvl_r  <= OD_WDATA;
                    `ICON_SUB_THRESH:   RANGE_24V  <= OD_WDATA;       // RL16
                    `ICON_SUB_DIFF:     DIFF_SEL   <= OD_WDATA;
                    `ICON_SUB_ROUTE_ON: route_on_r <= OD_WDATA;
                    default:            route_on_r <= route_on_r;
                endcase
            end
            p_rd_r    <= req;
            p_route_r <= OD_RD && od_route;
            p_err_r   <= req && (!hit || (OD_WR && ro));
            p_data_r  <= OD_RD ? rd_mux : `ICON_RST_WORD;
            OD_ACK    <= p_rd_r;
            OD_ERR    <= p_rd_r && p_err_r;
            OD_RDATA  <= p_err_r ? `ICON_RST_WORD :
                         p_route_r ? {24'h000000, mem_rdata} : p_data_r;
        end
    end

    // Routing scan walks the table one entry per cycle; a host
    // access to the table steals the read port and delays the walk
    always @(posedge CLOCK) begin
        if (SRST) begin
            scan_idx_r   <= 5'h00;
            scan_pidx_r  <= 5'h00;
            scan_pend_r  <= 1'b0;
            route_bits_r <= `ICON_RST_WORD;
        end else begin
            scan_pend_r <= !mem_od;
            scan_pidx_r <= scan_idx_r;
            if (!mem_od) begin
                scan_idx_r <= scan_idx_r + 5'h01;
            end
            if (scan_pend_r) begin
                route_bits_r[scan_pidx_r] <=
                    src_level(mem_rdata, cond, DIP_SW);  // RL18
            end
        end
    end

    // Summary word and conditioned outputs
    wire [31:0] plain_sum = {cond, 13'h0000, sf_act};  // RL17
    integer b;
    reg [31:0] sum_nxt;
    always @* begin
        sum_nxt = plain_sum;
        for (b = 0; b < 32; b = b + 1) begin
            if (route_on_r[0]) begin
                sum_nxt[b] = route_bits_r[b];  // RL18
            end
        end
    end

    always @(posedge CLOCK) begin
        if (SRST) begin
            DIGITAL_INPUTS <= `ICON_RST_WORD;
            NEG_LIMIT      <= 1'b0;
            POS_LIMIT      <= 1'b0;
            HOME_SW        <= 1'b0;
            DOUT           <= 16'h0000;
            ANA_PHYS_ONE   <= `ICON_RST_WORD;
            ANA_PHYS_TWO   <= `ICON_RST_WORD;
        end else begin
            DIGITAL_INPUTS <= sum_nxt;  // RL17 RL19
            NEG_LIMIT      <= sf_act[`ICON_SF_NEG_LIMIT];  // RL9
            POS_LIMIT      <= sf_act[`ICON_SF_POS_LIMIT];  // RL9
            HOME_SW        <= sf_act[`ICON_SF_HOME];  // RL9
            DOUT           <= out_lvl;  // RL7
            ANA_PHYS_ONE   <= prod1 >>> `ICON_SCALE_SHIFT;  // RL2 RL3
            ANA_PHYS_TWO   <= prod2 >>> `ICON_SCALE_SHIFT;  // RL2 RL3
        end
    end
endmodule // icon_top

// file: bench/icon_top_monitor.sv
// Assertions on the object port
`timescale 1ns/1ps
`include "icon_defines.vh"
module icon_top_monitor (
    input logic        CLOCK,                     // system clock
    input logic        SRST,                      // synchronous reset
    input logic [15:0] OD_INDEX,                  // object index
    input logic [7:0]  OD_SUB,                    // subindex
    input logic        OD_WR,                     // write request
    input logic        OD_RD,                     // read request
    input logic [31:0] OD_WDATA,                  // write data
    input logic [31:0] OD_RDATA,                  // read data
    input logic        OD_ACK,                    // answer pulse
    input logic        OD_ERR,                    // abort flag
    input logic        first_analog_current_sel,  // input one current
    input logic        second_analog_current_sel, // input two current
    input logic [31:0] RANGE_24V                  // threshold select
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);

    sequence s_req;
        OD_RD || OD_WR;
    endsequence
    sequence s_answer;
        ##2 OD_ACK;
    endsequence
    sequence s_wr_to(i, s);
        OD_WR && OD_INDEX == i && OD_SUB == s;
    endsequence
    // Lone write
    sequence s_wr_alone(i, s);
        s_wr_to(i, s) ##1 !OD_WR;
    endsequence

    a_ack_timing: assert property (s_req |-> s_answer)
        else $error("late answer");
    a_ack_cause: assert property (OD_ACK |-> $past(OD_RD || OD_WR, 2))
        else $error("stray answer");
    a_err_quiet: assert property (OD_ERR |-> OD_ACK && OD_RDATA == 32'h0)
        else $error("bad abort");
    a_idle_rdata: assert property (!OD_ACK |-> OD_RDATA == 32'h0)
        else $error("stray data");
    a_write_nodata: assert property (OD_WR |-> ##2 OD_RDATA == 32'h0)
        else $error("write data");
    a_analog_ro: assert property (OD_WR && OD_INDEX == `ICON_IDX_ANALOG |->
        ##2 OD_ERR) else $error("analog written");
    a_switch_ro: assert property (OD_WR && OD_INDEX == `ICON_IDX_SWITCHES |->
        ##2 OD_ERR) else $error("switch written");
    a_mode_copy: assert property (s_wr_alone(16'h3221, 8'h00) |-> ##1
        (first_analog_current_sel == $past(OD_WDATA[0], 2) &&
         second_analog_current_sel == $past(OD_WDATA[1], 2)))
        else $error("mode copy");
    a_range_copy: assert property (s_wr_alone(16'h3240, 8'h06) |-> ##1
        RANGE_24V == $past(OD_WDATA, 2))
        else $error("range copy");
endmodule // icon_top_monitor

bind icon_top icon_top_monitor i_mon (.CLOCK(CLOCK), .SRST(SRST),
    .OD_INDEX(OD_INDEX), .OD_SUB(OD_SUB), .OD_WR(OD_WR), .OD_RD(OD_RD),
    .OD_WDATA(OD_WDATA), .OD_RDATA(OD_RDATA), .OD_ACK(OD_ACK),
    .OD_ERR(OD_ERR), .first_analog_current_sel(first_analog_current_sel),
    .second_analog_current_sel(second_analog_current_sel),
    .RANGE_24V(RANGE_24V));

// file: bench/icon_field_model.sv
// Field side model: sensors, switches, analog sources
`timescale 1ns/1ps
module icon_field_model (
    input  logic        clk,               // system clock
    output logic [15:0] din = 16'h0,       // input levels
    output logic [15:0] ana_one = 16'h0,   // count, input one
    output logic [15:0] ana_two = 16'h0,   // count, input two
    output logic        ana_valid = 1'b0,  // new samples
    output logic [7:0]  node_sw = 8'h0,    // rotary node switch
    output logic [7:0]  dip_sw = 8'h0,     // DIP switch positions
    output logic        dip_fitted = 1'b0  // DIP switches fitted
);
    // Bench commands, applied at the falling edge
    logic [15:0] lvl_cmd = 16'h0;
    logic [15:0] a1_cmd = 16'h0;
    logic [15:0] a2_cmd = 16'h0;
    logic        av_cmd = 1'b0;
    logic [7:0]  node_cmd = 8'h0;
    logic [7:0]  dip_cmd = 8'h0;
    logic        fit_cmd = 1'b0;

    // Off the sampling edge, so no race
    always @(negedge clk) begin
        din <= lvl_cmd;
        ana_one <= a1_cmd;
        ana_two <= a2_cmd;
        ana_valid <= av_cmd;
        node_sw <= node_cmd;
        dip_sw <= dip_cmd;
        dip_fitted <= fit_cmd;
    end
endmodule // icon_field_model

// file: bench/tb.sv
// Bench for the input conditioning objects
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [15:0] idx;
        logic [7:0]  sub;
        logic [31:0] wd;
        logic [31:0] rd;
        logic        werr;
        logic        rerr;
    } icon_row_t;
    localparam logic [15:0] STEP = 16'h0003;
    logic        CLOCK, SRST, OD_WR, OD_RD, OD_ACK, OD_ERR, ANA_VALID;
    logic [15:0] OD_INDEX, ANA_SAMPLE_ONE, ANA_SAMPLE_TWO, DIN, OUT_REQ, DOUT;
    logic [7:0]  OD_SUB, NODE_ID_SW, DIP_SW;
    logic [31:0] OD_WDATA, OD_RDATA, ANA_PHYS_ONE, ANA_PHYS_TWO, RANGE_24V;
    logic [31:0] DIFF_SEL, DIGITAL_INPUTS, rd_v, e;
    logic        first_analog_current_sel, second_analog_current_sel;
    logic        DIP_FITTED, STEP_MODE, NEG_LIMIT, POS_LIMIT, HOME_SW, err_v;
    logic [15:0] c;
    int          mismatches = 0;
    int          samples_checked = 0;
    icon_row_t   rows [0:11] = '{
        '{16'h3221, 8'h00, 32'hffffffff, 32'h3, 1'b0, 1'b0},
        '{16'h3240, 8'h06, 32'ha5a55a5a, 32'ha5a55a5a, 1'b0, 1'b0},
        '{16'h3240, 8'h07, 32'h12345678, 32'h12345678, 1'b0, 1'b0},
        '{16'h3242, 8'h01, 32'h000001ff, 32'hff, 1'b0, 1'b0},
        '{16'h3242, 8'h00, 32'h1, 32'h24, 1'b1, 1'b0},
        '{16'h3220, 8'h00, 32'h1, 32'h2, 1'b1, 1'b0},
        '{16'h3220, 8'h01, 32'hffff, 32'h0300, 1'b1, 1'b0},
        '{16'h3225, 8'h00, 32'h1, 32'h1, 1'b1, 1'b0},
        '{16'h3225, 8'h01, 32'h1, 32'h2a, 1'b1, 1'b0},
        '{16'h3240, 8'h00, 32'h1, 32'h8, 1'b1, 1'b0},
        '{16'h3240, 8'h09, 32'h1, 32'h0, 1'b1, 1'b1},
        '{16'h3240, 8'h05, 32'hdeadbeef, 32'h0, 1'b0, 1'b0}};

    icon_top #(.STEP_MASK(STEP)) i_dut (.CLOCK(CLOCK), .SRST(SRST),
        .OD_INDEX(OD_INDEX), .OD_SUB(OD_SUB), .OD_WR(OD_WR), .OD_RD(OD_RD),
        .OD_WDATA(OD_WDATA), .OD_RDATA(OD_RDATA), .OD_ACK(OD_ACK),
        .OD_ERR(OD_ERR), .ANA_SAMPLE_ONE(ANA_SAMPLE_ONE),
        .ANA_SAMPLE_TWO(ANA_SAMPLE_TWO), .ANA_VALID(ANA_VALID),
        .ANA_PHYS_ONE(ANA_PHYS_ONE), .ANA_PHYS_TWO(ANA_PHYS_TWO),
        .first_analog_current_sel(first_analog_current_sel),
        .second_analog_current_sel(second_analog_current_sel),
        .NODE_ID_SW(NODE_ID_SW), .DIP_SW(DIP_SW), .DIP_FITTED(DIP_FITTED),
        .DIN(DIN), .STEP_MODE(STEP_MODE), .OUT_REQ(OUT_REQ), .DOUT(DOUT),
        .RANGE_24V(RANGE_24V), .DIFF_SEL(DIFF_SEL), .NEG_LIMIT(NEG_LIMIT),
        .POS_LIMIT(POS_LIMIT), .HOME_SW(HOME_SW),
        .DIGITAL_INPUTS(DIGITAL_INPUTS));
    icon_field_model i_field (.clk(CLOCK), .din(DIN), .ana_one(ANA_SAMPLE_ONE),
        .ana_two(ANA_SAMPLE_TWO), .ana_valid(ANA_VALID), .node_sw(NODE_ID_SW),
        .dip_sw(DIP_SW), .dip_fitted(DIP_FITTED));

    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end

    task automatic finish_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One request, then a bounded wait for the answer
    task automatic od(input logic wr, input logic [15:0] idx,
                      input logic [7:0] sub, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
        int n;
        @(negedge CLOCK);
        OD_WR = wr;
        OD_RD = !wr;
        OD_INDEX = idx;
        OD_SUB = sub;
        OD_WDATA = wd;
        @(negedge CLOCK);
        OD_WR = 1'b0;
        OD_RD = 1'b0;
        for (n = 0; n < 8 && OD_ACK !== 1'b1; n++) @(negedge CLOCK);
        rd = OD_RDATA;
        err = OD_ERR;
        if (OD_ACK !== 1'b1) begin
            mismatches++;
            finish_test;
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd);
        od(1'b1, idx, sub, wd, rd_v, err_v);
        chk({31'h0, err_v}, 32'h0);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] exp);
        od(1'b0, idx, sub, 32'h0, rd_v, err_v);
        chk({err_v, rd_v[30:0]}, exp);
    endtask

    task automatic do_reset;
        SRST = 1'b1;
        repeat (4) @(negedge CLOCK);
        SRST = 1'b0;
    endtask

    // Bit 2 forced high, bit 8 forced low, bits 0..3 inverted (only 2..3 in step mode)
    function automatic logic [15:0] cond_f(input logic [15:0] d,
                                           input logic st);
        return ((d & ~16'h0104) | 16'h0004) ^
               (16'h000f & ~(st ? STEP : 16'h0000));
    endfunction

    function automatic logic [31:0] phys_f(input int x, input logic cur);
        int v;
        v = cur ? x : x - 512;
        return (v * 625) >>> 5;
    endfunction

    initial begin
        int i;
        logic [15:0] dv [0:2];
        logic [7:0] codes [0:3];
        dv = '{16'h0000, 16'hffff, 16'h5a3c};
        codes = '{8'h80, 8'h01, 8'h81, 8'h49};
        SRST = 1'b1;
        OD_WR = 1'b0;
        OD_RD = 1'b0;
        OD_INDEX = 16'h0;
        OD_SUB = 8'h0;
        OD_WDATA = 32'h0;
        STEP_MODE = 1'b0;
        OUT_REQ = 16'h00f0;
        i_field.a1_cmd = 16'h0300;
        i_field.a2_cmd = 16'h0100;
        i_field.av_cmd = 1'b1;
        i_field.node_cmd = 8'h2a;
        do_reset;
        for (i = 0; i < 12; i++) begin
            od(1'b1, rows[i].idx, rows[i].sub, rows[i].wd, rd_v, err_v);
            chk({31'h0, err_v}, {31'h0, rows[i].werr});
            od(1'b0, rows[i].idx, rows[i].sub, 32'h0, rd_v, err_v);
            chk({31'h0, err_v}, {31'h0, rows[i].rerr});
            chk(rd_v, rows[i].rd);
        end
        i_field.fit_cmd = 1'b1;
        i_field.dip_cmd = 8'h81;
        repeat (3) @(negedge CLOCK);
        rdc(16'h3225, 8'h01, 32'h81);
        wr(16'h3240, 8'h01, 32'hffff0005);
        wr(16'h3240, 8'h02, 32'h0003000f);
        wr(16'h3240, 8'h03, 32'h01010104);
        wr(16'h3240, 8'h04, 32'h01000004);
        for (i = 0; i < 6; i++) begin
            i_field.lvl_cmd = dv[i % 3];
            STEP_MODE = (i >= 3);
            repeat (4) @(negedge CLOCK);
            c = cond_f(dv[i % 3], i >= 3);
            e = {29'h0, c[2:0] & 3'b101};
            chk(DIGITAL_INPUTS, {c, e[15:0]});
            chk({29'h0, HOME_SW, POS_LIMIT, NEG_LIMIT}, e);
            rdc(16'h3240, 8'h05, {16'h0, dv[i % 3]});
        end
        chk({16'h0, DOUT}, 32'h000001f3);
        for (i = 0; i < 4; i++) begin
            wr(16'h3221, 8'h00, i);
            repeat (3) @(negedge CLOCK);
            chk(ANA_PHYS_ONE, phys_f(32'h300, i[0]));
            chk(ANA_PHYS_TWO, phys_f(32'h100, i[1]));
            chk({30'h0, second_analog_current_sel,
                 first_analog_current_sel}, i);
        end
        i_field.av_cmd = 1'b0;
        i_field.lvl_cmd = 16'h0000;
        STEP_MODE = 1'b0;
        repeat (2) @(negedge CLOCK);
        do_reset;
        rdc(16'h3220, 8'h01, 32'h0);
        rdc(16'h3220, 8'h02, 32'h0);
        rdc(16'h3221, 8'h00, 32'h0);
        for (i = 1; i < 9; i++) rdc(16'h3240, i[7:0], 32'h0);
        rdc(16'h3242, 8'h01, 32'h0);
        i_field.lvl_cmd = 16'h0001;
        wr(16'h3240, 8'h08, 32'h1);
        for (i = 1; i < 5; i++) wr(16'h3242, i[7:0], {24'h0, codes[i - 1]});
        repeat (40) @(negedge CLOCK);
        chk(DIGITAL_INPUTS, 32'h0000000b);
        i_field.lvl_cmd = 16'h0000;
        repeat (40) @(negedge CLOCK);
        chk(DIGITAL_INPUTS, 32'h0000000d);
        finish_test;
    end
endmodule // tb
